// ### dv/bcsr_pcie_side.sv
`timescale 1ns/1ps
`default_nettype none
module bcsr_pcie_side (
	input  wire logic                i_kick_en,
	input  wire bcsr_pkg::bcsr_evt_t i_kick,
	input  wire logic                i_system_error_signalled_en,
	input  wire logic                i_rogue,
	output wire bcsr_pkg::bcsr_evt_t o_evt
);
	// Error messages held back unless enabled, or forced through
	assign o_evt = i_kick & {7{i_kick_en}} & {1'b1, i_system_error_signalled_en || i_rogue, 5'h1f};
endmodule
`default_nettype wire

// ### dv/bcsr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bcsr_regs_monitor #(
	parameter logic [7:0] SILICON_REV = 8'h01
) (
	input wire logic                    i_clk,
	input wire logic                    i_sys_rst,
	input wire bcsr_pkg::bcsr_cfg_req_t i_cfg_req,
	input wire bcsr_pkg::bcsr_evt_t     i_evt,
	input wire logic                    o_cfg_ack,
	input wire logic [31:0]             o_cfg_rdata,
	input wire logic                    o_parity_response_enable,
	input wire logic                    o_system_error_enable,
	input wire logic [7:0]              o_prefetch_dwords
);
	// ==========================================================
	// Decode
	wire logic [5:0] dw = i_cfg_req.addr[7:2];
	wire logic       rd = i_cfg_req.rd && !i_cfg_req.wr;
	wire logic       wr = i_cfg_req.wr;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);
	function automatic logic [7:0] lsz(logic [7:0] v);
		return (v[0] || v > 8'h20) ? 8'h00 : v;
	endfunction
	sequence s_rd_st;
		rd && dw == 6'h01;
	endsequence
	property p_flag(ev, b);
		ev ##1 s_rd_st |=> o_cfg_rdata[b];
	endproperty
	// ==========================================================
	// Assertions
	a_ack_next: assert property ((i_cfg_req.rd || i_cfg_req.wr) |=> o_cfg_ack) else $error("ack missing");
	a_class_rev: assert property (rd && dw == 6'h02 |=> o_cfg_rdata == {8'h06, 8'h04, 8'h00, SILICON_REV})
		else $error("class bad");
	a_status_fixed: assert property (s_rd_st |=> o_cfg_rdata[26:25] == 2'h0 && o_cfg_rdata[23:16] == 8'h10)
		else $error("status fixed bits bad");
	a_lat_zero: assert property (rd && dw == 6'h03 |=> o_cfg_rdata[15:8] == 8'h00) else $error("lat bad");
	a_line_clamp: assert property (wr && dw == 6'h03 && i_cfg_req.be[0]
		|=> o_prefetch_dwords == lsz($past(i_cfg_req.wdata[7:0]))) else $error("prefetch bad");
	a_perr_enable: assert property (wr && dw == 6'h01 && i_cfg_req.be[0]
		|=> o_parity_response_enable == $past(i_cfg_req.wdata[6])) else $error("perr enable bad");
	a_serr_enable: assert property (wr && dw == 6'h01 && i_cfg_req.be[1]
		|=> o_system_error_enable == $past(i_cfg_req.wdata[8])) else $error("serr enable bad");
	a_poison_flag: assert property (p_flag(i_evt.poisoned_tlp_rx, 31)) else $error("bit15 bad");
	a_system_error_signalled_flag: assert property (p_flag(i_evt.err_msg_sent && o_system_error_enable, 30))
		else $error("bit14 bad");
	a_ur_flag: assert property (p_flag(i_evt.ur_cpl_rx, 29)) else $error("bit13 bad");
	a_ca_rx_flag: assert property (p_flag(i_evt.ca_cpl_rx, 28)) else $error("bit12 bad");
	a_ca_sig_flag: assert property (p_flag(i_evt.ca_cpl_sent, 27)) else $error("bit11 bad");
	a_master_poison: assert property (p_flag((i_evt.poisoned_cpl_data_rx || i_evt.poisoned_wr_rx)
		&& o_parity_response_enable, 24)) else $error("bit8 bad");
	a_w1c_clear: assert property (wr && dw == 6'h01 && i_cfg_req.be[3] && i_cfg_req.wdata[31]
		&& !i_evt.poisoned_tlp_rx ##1 !i_evt.poisoned_tlp_rx ##1 s_rd_st
		|=> !o_cfg_rdata[31]) else $error("clear bad");
endmodule
bind bcsr_regs bcsr_regs_monitor #(.SILICON_REV(SILICON_REV)) u_mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_cfg_req(i_cfg_req), .i_evt(i_evt), .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata),
	.o_parity_response_enable(o_parity_response_enable), .o_system_error_enable(o_system_error_enable),
	.o_prefetch_dwords(o_prefetch_dwords));
`default_nettype wire

// ### dv/bcsr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bcsr_regs_tb;
	localparam logic [7:0] REV = 8'h5a;
	localparam logic [7:0] LS [0:9] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h00, 8'h03, 8'h21, 8'h40, 8'hff};
	logic                    i_clk;
	logic                    i_sys_rst;
	bcsr_pkg::bcsr_cfg_req_t req;
	bcsr_pkg::bcsr_evt_t     kick;
	bcsr_pkg::bcsr_evt_t     evt;
	bcsr_pkg::bcsr_evt_t     e;
	logic                    rogue;
	logic                    ack;
	logic [31:0]             rdata;
	logic                    pen;
	logic                    sen;
	logic [7:0]              pf;
	logic [5:0]              fl;
	logic                    men;
	logic                    msen;
	logic [31:0]             rv;
	logic [31:0]             r;
	logic [7:0]              w;
	int                      errors;
	int                      n_tests;
	int                      seed;

	bcsr_regs #(.SILICON_REV(REV)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cfg_req(req), .i_evt(evt),
		.o_cfg_ack(ack), .o_cfg_rdata(rdata), .o_parity_response_enable(pen),
		.o_system_error_enable(sen), .o_prefetch_dwords(pf));
	bcsr_pcie_side far (.i_kick_en(1'b1), .i_kick(kick), .i_system_error_signalled_en(sen), .i_rogue(rogue), .o_evt(evt));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	function automatic logic [15:0] stat(logic [5:0] f);
		return {f[0], f[1], f[2], f[3], f[4], 2'h0, f[5], 8'h10};
	endfunction
	function automatic logic [7:0] lsz(logic [7:0] v);
		return (v[0] || v > 8'h20) ? 8'h00 : v;
	endfunction
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic acc(logic rd, logic wr, logic [7:0] a, logic [3:0] be, logic [31:0] wd);
		int k;
		@(negedge i_clk);
		req = '{rd, wr, a, be, wd};
		@(negedge i_clk);
		req = '0;
		for (k = 0; k < 4 && ack !== 1'b1; k++)
			@(negedge i_clk);
		if (k == 4) begin
			errors++;
			conclude();
		end else begin
			rv = rdata;
		end
	endtask
	task automatic ev(logic [6:0] x);
		@(negedge i_clk);
		kick = x;
		@(negedge i_clk);
		kick = '0;
	endtask

	initial begin
		seed = 32'h82bd714c;
		errors = 0;
		n_tests = 0;
		req = '0;
		kick = '0;
		rogue = 1'b0;
		fl = '0;
		i_sys_rst = 1'b1;
		repeat (12) @(negedge i_clk);
		i_sys_rst = 1'b0;
		// ==========================================================
		// Reset contents, read-only and unmapped places
		acc(1'b1, 1'b0, 8'h04, 4'h0, 32'h0);
		chk("status_cmd", rv, {stat(6'h0), 16'h0});
		acc(1'b0, 1'b1, 8'h08, 4'hf, 32'hffff_ffff);
		acc(1'b1, 1'b0, 8'h08, 4'h0, 32'h0);
		chk("class_rev", rv, {8'h06, 8'h04, 8'h00, REV});
		acc(1'b1, 1'b0, 8'h40, 4'h0, 32'h0);
		chk("unmapped", rv, 32'h0);
		$display("reset test done");
		// ==========================================================
		// Random events, enables and write-one clears
		repeat (80) begin
			r = $random(seed);
			{rogue, msen, men} = r[2:0];
			acc(1'b0, 1'b1, 8'h04, 4'h3, {r[31:16], 7'h0, msen, 1'b0, men, 6'h0});
			chk("enables", {pen, sen}, {men, msen});
			e = r[9:3];
			fl |= {(e.poisoned_cpl_data_rx | e.poisoned_wr_rx) & men, e.ca_cpl_sent, e.ca_cpl_rx,
				e.ur_cpl_rx, e.err_msg_sent & msen, e.poisoned_tlp_rx};
			// Status read in the cycle right after the event
			fork
				ev(e);
				begin
					@(negedge i_clk);
					acc(1'b1, 1'b0, 8'h04, 4'h0, 32'h0);
				end
			join
			chk("flags_set", rv[31:16], stat(fl));
			acc(1'b0, 1'b1, 8'h04, 4'hc, {stat(r[15:10]), 16'hffff});
			fl &= ~r[15:10];
			acc(1'b1, 1'b0, 8'h04, 4'h0, 32'h0);
			chk("flags_clr", rv, {stat(fl), 7'h0, msen, 1'b0, men, 6'h0});
		end
		fork
			ev(7'h40);
			acc(1'b0, 1'b1, 8'h04, 4'hc, 32'h8000_0000);
		join
		fl[0] = 1'b1;
		acc(1'b1, 1'b0, 8'h04, 4'h0, 32'h0);
		chk("set_wins", rv[31:16], stat(fl));
		$display("event test done");
		// ==========================================================
		// Line size table then random sizes
		for (int i = 0; i < 30; i++) begin
			r = $random(seed);
			w = (i < 10) ? LS[i] : r[7:0];
			acc(1'b0, 1'b1, 8'h0c, 4'hf, {r[31:8], w});
			chk("prefetch", pf, lsz(w));
			acc(1'b1, 1'b0, 8'h0c, 4'h0, 32'h0);
			chk("line_lat", rv, {24'h0, w});
		end
		$display("line size test done");
		@(negedge i_clk);
		i_sys_rst = 1'b1;
		repeat (2) @(negedge i_clk);
		i_sys_rst = 1'b0;
		acc(1'b1, 1'b0, 8'h04, 4'h0, 32'h0);
		chk("status_rerst", rv, {stat(6'h0), 16'h0});
		chk("prefetch_rerst", pf, 32'h0);
		$display("mid reset test done");
		conclude();
	end
endmodule
`default_nettype wire

// ### hw/bcsr_pkg.sv
package bcsr_pkg;

	// ==========================================================
	// Access port geometry
	localparam int unsigned ADDR_W          = 8;
	localparam int unsigned DATA_W          = 32;
	localparam int unsigned BE_W            = 4;
	localparam int unsigned LANE_W          = 8;

	// ==========================================================
	// Register offsets
	localparam logic [7:0]  OFF_COMMAND     = 8'h04;
	localparam logic [7:0]  OFF_STATUS      = 8'h06;
	localparam logic [7:0]  OFF_CLASS_REV   = 8'h08;
	localparam logic [7:0]  OFF_LINE_SIZE   = 8'h0c;
	localparam logic [7:0]  OFF_LAT_TIMER   = 8'h0d;
	localparam logic [7:0]  DWORD_MASK      = 8'hfc;

	// ==========================================================
	// Command bit positions and reset values
	localparam int unsigned CMD_PARITY_RESP = 6;
	localparam int unsigned CMD_SYSTEM_ERROR_SIGNALLED_EN  = 8;
	localparam logic        CMD_EN_RESET    = 1'b0;

	// ==========================================================
	// Status layout
	localparam int unsigned ST_POISON_RX    = 15;
	localparam int unsigned ST_SYSTEM_ERROR_SIGNALLED      = 14;
	localparam int unsigned ST_UR_RX        = 13;
	localparam int unsigned ST_CA_RX        = 12;
	localparam int unsigned ST_CA_SIG       = 11;
	localparam int unsigned ST_MASTER_PSN   = 8;
	localparam int unsigned NUM_FLAGS       = 6;
	localparam int unsigned FLAG_POS [0:5]  = '{15, 14, 13, 12, 11, 8};
	localparam int unsigned FLG_POISON_RX   = 0;
	localparam int unsigned FLG_SYSTEM_ERROR_SIGNALLED     = 1;
	localparam int unsigned FLG_UR_RX       = 2;
	localparam int unsigned FLG_CA_RX       = 3;
	localparam int unsigned FLG_CA_SIG      = 4;
	localparam int unsigned FLG_MASTER_PSN  = 5;
	localparam logic [15:0] STATUS_FIXED    = 16'h0010;
	localparam logic [15:0] STATUS_RESET    = 16'h0010;
	localparam logic        FLAG_RESET      = 1'b0;

	// ==========================================================
	// Class code and revision
	localparam logic [7:0]  DEVICE_CATEGORY = 8'h06;
	localparam logic [7:0]  BRIDGE_SUBCLASS = 8'h04;
	localparam logic [7:0]  PROG_IF_CODE    = 8'h00;
	// Arbitrary neutral value
	localparam logic [7:0]  SILICON_REV_DEF = 8'h01;

	// ==========================================================
	// Line size and latency timer
	localparam logic [7:0]  LINE_SIZE_RESET = 8'h00;
	localparam logic [7:0]  LINE_SIZE_MAX   = 8'h20;
	localparam logic [7:0]  LINE_SIZE_ZERO  = 8'h00;
	localparam logic [7:0]  LAT_TIMER_VALUE = 8'h00;
	localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} bcsr_cfg_req_t;

	typedef struct packed {
		logic poisoned_tlp_rx;
		logic err_msg_sent;
		logic ur_cpl_rx;
		logic ca_cpl_rx;
		logic ca_cpl_sent;
		logic poisoned_cpl_data_rx;
		logic poisoned_wr_rx;
	} bcsr_evt_t;

endpackage

// ### hw/bcsr_regs.sv
// Overview of operation
// - Poisoned packet received sets status bit 15, whatever parity response says.
// - Error message sent sets status bit 14 when system error enable is set.
// - Unsupported-request completion received sets status bit 13.
// - Completer-abort completion received sets status bit 12.
// - Answering a request with completer-abort sets status bit 11.
// - Poisoned completion data or poisoned write sets bit 8, only with parity response.
// - Status bits 10:9 always read 00b.
// - Status bit 4 reads 1b, capabilities list present.
// - Status bits 7, 6, 5, 3 and 2:0 read zero.
// - Class code reads 06h, 04h, 00h in the upper three bytes.
// - Bits 7:0 of class register return the silicon revision.
// - Programmed line size steers the prefetch amount for delayed reads.
// - Odd line size, or above 32 dwords, counts as zero.
// - Primary latency timer is read-only and returns 00h.
// - Command bit 6 parity response enable, default 0, gates the master poison flag.
// - Command bit 8 system error enable, default 0, gates error reporting.
`timescale 1ns/1ps
`default_nettype none

module bcsr_regs #(
	parameter logic [7:0] SILICON_REV = bcsr_pkg::SILICON_REV_DEF
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_sys_rst,
	input  wire bcsr_pkg::bcsr_cfg_req_t i_cfg_req,
	input  wire bcsr_pkg::bcsr_evt_t     i_evt,
	output var  logic                   o_cfg_ack,
	output var  logic [31:0]            o_cfg_rdata,
	output var  logic                   o_parity_response_enable,
	output var  logic                   o_system_error_enable,
	output var  logic [7:0]             o_prefetch_dwords
);

	// ==========================================================
	// Decode helpers
	function automatic logic dword_hit(
		input logic [7:0] addr,
		input logic [7:0] off
	);
		dword_hit = (addr & bcsr_pkg::DWORD_MASK) == (off & bcsr_pkg::DWORD_MASK);
	endfunction

	function automatic logic lane_wr(
		input bcsr_pkg::bcsr_cfg_req_t req,
		input logic [7:0]              off
	);
		lane_wr = req.wr & dword_hit(req.addr, off) & req.be[off[1:0]];
	endfunction

	function automatic logic [7:0] line_size_effective(
		input logic [7:0] raw
	);
		if (raw[0] || (raw > bcsr_pkg::LINE_SIZE_MAX)) begin
			line_size_effective = bcsr_pkg::LINE_SIZE_ZERO;
		end else begin
			line_size_effective = raw;
		end
	endfunction

	// ==========================================================
	// Request decode
	logic        cmd_lo_wr;
	logic        cmd_hi_wr;
	logic        status_lo_wr;
	logic        status_hi_wr;
	logic        line_size_wr;
	logic [7:0]  wr_byte0;
	logic [7:0]  wr_byte1;
	logic [7:0]  wr_byte2;
	logic [7:0]  wr_byte3;
	logic        any_access;

	assign cmd_lo_wr    = lane_wr(i_cfg_req, bcsr_pkg::OFF_COMMAND);
	assign cmd_hi_wr    = lane_wr(i_cfg_req, bcsr_pkg::OFF_COMMAND + 8'h01);
	assign status_lo_wr = lane_wr(i_cfg_req, bcsr_pkg::OFF_STATUS);
	assign status_hi_wr = lane_wr(i_cfg_req, bcsr_pkg::OFF_STATUS + 8'h01);
	assign line_size_wr = lane_wr(i_cfg_req, bcsr_pkg::OFF_LINE_SIZE);
	assign wr_byte0     = i_cfg_req.wdata[7:0];
	assign wr_byte1     = i_cfg_req.wdata[15:8];
	assign wr_byte2     = i_cfg_req.wdata[23:16];
	assign wr_byte3     = i_cfg_req.wdata[31:24];
	assign any_access   = i_cfg_req.rd | i_cfg_req.wr;

	// ==========================================================
	// Command enables
	logic perr_en_d;
	logic serr_en_d;

	assign perr_en_d = cmd_lo_wr ? wr_byte0[bcsr_pkg::CMD_PARITY_RESP] : o_parity_response_enable;
	assign serr_en_d = cmd_hi_wr ? wr_byte1[bcsr_pkg::CMD_SYSTEM_ERROR_SIGNALLED_EN - bcsr_pkg::LANE_W] :
		o_system_error_enable;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_parity_response_enable <= bcsr_pkg::CMD_EN_RESET;
			o_system_error_enable    <= bcsr_pkg::CMD_EN_RESET;
		end else begin
			o_parity_response_enable <= perr_en_d;
			o_system_error_enable    <= serr_en_d;
		end
	end

	// ==========================================================
	// Error flag events
	logic [bcsr_pkg::NUM_FLAGS-1:0] flag_set;
	logic [bcsr_pkg::NUM_FLAGS-1:0] flag_clr;
	logic [bcsr_pkg::NUM_FLAGS-1:0] flag_q;

	assign flag_set[bcsr_pkg::FLG_POISON_RX]  = i_evt.poisoned_tlp_rx;
	assign flag_set[bcsr_pkg::FLG_SYSTEM_ERROR_SIGNALLED]    = i_evt.err_msg_sent & o_system_error_enable;
	assign flag_set[bcsr_pkg::FLG_UR_RX]      = i_evt.ur_cpl_rx;
	assign flag_set[bcsr_pkg::FLG_CA_RX]      = i_evt.ca_cpl_rx;
	assign flag_set[bcsr_pkg::FLG_CA_SIG]     = i_evt.ca_cpl_sent;
	assign flag_set[bcsr_pkg::FLG_MASTER_PSN] = o_parity_response_enable &
		(i_evt.poisoned_cpl_data_rx | i_evt.poisoned_wr_rx);

	// ==========================================================
	// Write-one-to-clear flags
	genvar gi;
	generate
		for (gi = 0; gi < bcsr_pkg::NUM_FLAGS; gi++) begin : g_flag
			localparam int unsigned POS = bcsr_pkg::FLAG_POS[gi];
			if (POS >= bcsr_pkg::LANE_W) begin : g_hi
				assign flag_clr[gi] = status_hi_wr & wr_byte3[POS-bcsr_pkg::LANE_W];
			end else begin : g_lo
				assign flag_clr[gi] = status_lo_wr & wr_byte2[POS];
			end
			bcsr_w1c_flag #(
				.RESET_VAL (bcsr_pkg::FLAG_RESET)
			) u_flag (
				.i_clk     (i_clk),
				.i_sys_rst (i_sys_rst),
				.i_set     (flag_set[gi]),
				.i_clr     (flag_clr[gi]),
				.o_flag    (flag_q[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Status image
	logic [15:0] status_flags;
	logic [15:0] status_word;

	always_comb begin
		status_flags = 16'h0000;
		for (int k = 0; k < bcsr_pkg::NUM_FLAGS; k++) begin
			status_flags[bcsr_pkg::FLAG_POS[k]] = flag_q[k];
		end
	end

	// Fixed part holds bit 4 set, bits 10:9, 7, 6, 5, 3, 2:0 zero
	assign status_word = status_flags | bcsr_pkg::STATUS_FIXED;

	// ==========================================================
	// Line size
	logic [7:0] line_size_q;
	logic [7:0] line_size_d;
	logic [7:0] prefetch_d;

	assign line_size_d = line_size_wr ? wr_byte0 : line_size_q;
	// Even non power of two values up to 20h pass through as written
	assign prefetch_d  = line_size_effective(line_size_d);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			line_size_q       <= bcsr_pkg::LINE_SIZE_RESET;
			o_prefetch_dwords <= bcsr_pkg::LINE_SIZE_RESET;
		end else begin
			line_size_q       <= line_size_d;
			o_prefetch_dwords <= prefetch_d;
		end
	end

	// ==========================================================
	// Read data
	logic [31:0] cmd_status_dw;
	logic [31:0] class_rev_dw;
	logic [31:0] line_lat_dw;
	logic [15:0] cmd_word;
	logic [31:0] rdata_d;

	always_comb begin
		cmd_word = 16'h0000;
		cmd_word[bcsr_pkg::CMD_PARITY_RESP] = o_parity_response_enable;
		cmd_word[bcsr_pkg::CMD_SYSTEM_ERROR_SIGNALLED_EN]  = o_system_error_enable;
	end

	assign cmd_status_dw = {status_word, cmd_word};
	assign class_rev_dw  = {bcsr_pkg::DEVICE_CATEGORY, bcsr_pkg::BRIDGE_SUBCLASS,
		bcsr_pkg::PROG_IF_CODE, SILICON_REV};
	assign line_lat_dw   = {16'h0000, bcsr_pkg::LAT_TIMER_VALUE, line_size_q};

	always_comb begin
		if (!i_cfg_req.rd) begin
			rdata_d = o_cfg_rdata;
		end else if (dword_hit(i_cfg_req.addr, bcsr_pkg::OFF_COMMAND)) begin
			rdata_d = cmd_status_dw;
		end else if (dword_hit(i_cfg_req.addr, bcsr_pkg::OFF_CLASS_REV)) begin
			rdata_d = class_rev_dw;
		end else if (dword_hit(i_cfg_req.addr, bcsr_pkg::OFF_LINE_SIZE)) begin
			rdata_d = line_lat_dw;
		end else begin
			rdata_d = bcsr_pkg::RDATA_RESET;
		end
	end

	// ==========================================================
	// Answer
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_cfg_ack   <= 1'b0;
			o_cfg_rdata <= bcsr_pkg::RDATA_RESET;
		end else begin
			o_cfg_ack   <= any_access;
			o_cfg_rdata <= rdata_d;
		end
	end

endmodule

`default_nettype wire

// ### hw/bcsr_w1c_flag.sv
`timescale 1ns/1ps
`default_nettype none

module bcsr_w1c_flag #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_set,
	input  wire logic i_clr,
	output var  logic o_flag
);

	logic flag_d;

	// Set wins over a clear in the same cycle
	assign flag_d = i_set | (o_flag & ~i_clr);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_flag <= RESET_VAL;
		end else begin
			o_flag <= flag_d;
		end
	end

endmodule

`default_nettype wire
